// >>> shared/drr_regs.svh
// Register offsets, field positions, reset values and bus widths of the DMA request router.
// Assumes a byte-addressed plain register port and one 200 MHz clock.
//
// Overview of operation
// - Writing one to bit 23 clears channel-1 machine.
// - Writing zero there changes no state.
// - Clear bit always reads back as zero.
// - Bits 22 to 20 read zero, ignore writes.
// - Bits 19 to 16 pick channel-1 requester.
// - Register maps requesters onto four channels independently; the router stores all four selectors but routes only channel 1.
// - Selector also steers acknowledge and done back.
// - Selector value n picks request input n.
`ifndef DRR_REGS_SVH
`define DRR_REGS_SVH

`define DRR_ADDR_W      8
`define DRR_DATA_W      32
`define DRR_NUM_REQ     16
`define DRR_NUM_CHAN    4
`define DRR_SEL_W       4

`define DRR_ROUTE_OFS   8'h00
`define DRR_STAT_OFS    8'h04

`define DRR_ROUTE_RST   32'h0000_0000
`define DRR_SEL_RST     4'h0

`define DRR_CH1_CLR_BIT 23
`define DRR_CH1_RSV_HI  22
`define DRR_CH1_RSV_LO  20
`define DRR_CH1_SEL_HI  19
`define DRR_CH1_SEL_LO  16
`define DRR_CHAN_LANE_W 8

`define DRR_STAT_STATE_LO 0
`define DRR_STAT_REQ_BIT  2

`endif

// >>> shared/drr_pkg.sv
// Types shared by the DMA request router and its channel state machine.
// Assumes drr_regs.svh supplies the widths.
`include "drr_regs.svh"

package drr_pkg;

    typedef enum logic [1:0]
    {
        DRR_IDLE = 2'b00,
        DRR_PEND = 2'b01,
        DRR_BUSY = 2'b10
    } drr_state_t;

    typedef logic [`DRR_SEL_W-1:0] drr_sel_t;

    // Completion handshake from the channel-1 engine.
    typedef struct packed
    {
        logic ack;
        logic done;
    } drr_eng_rsp_t;

    // Completion handshake steered back to the selected requester, one bit per requester.
    typedef struct packed
    {
        logic [`DRR_NUM_REQ-1:0] ack;
        logic [`DRR_NUM_REQ-1:0] done;
    } drr_per_rsp_t;

endpackage

// >>> rtl/drr_chan_fsm.sv
// Request handling state machine of one DMA channel.
// Assumes the engine answers a raised request with one ack pulse, then one done pulse.
module drr_chan_fsm
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Control
    input  wire logic                clearFsm,
    input  wire logic                reqIn,
    // Engine side
    input  wire drr_pkg::drr_eng_rsp_t engRsp,
    output logic                     engReq,
    // Status
    output drr_pkg::drr_state_t      state,
    output logic                     ackFire,
    output logic                     doneFire
);
    import drr_pkg::*;

    drr_state_t stateQ;
    drr_state_t stateD;

    always_comb
    begin
        stateD = stateQ;
        unique case (stateQ)
            DRR_IDLE:
            begin
                if (reqIn)
                    stateD = DRR_PEND;
            end
            DRR_PEND:
            begin
                if (engRsp.ack)
                    stateD = DRR_BUSY;
            end
            DRR_BUSY:
            begin
                if (engRsp.done)
                    stateD = DRR_IDLE;
            end
            default:
                stateD = DRR_IDLE;
        endcase
        // A clear overrides every transition, so stale work never survives a reroute.
        if (clearFsm)
            stateD = DRR_IDLE;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            stateQ <= DRR_IDLE;
        else
            stateQ <= stateD;
    end

    assign state    = stateQ;
    assign engReq   = (stateQ == DRR_PEND) && !clearFsm;
    assign ackFire  = (stateQ == DRR_PEND) && engRsp.ack && !clearFsm;
    assign doneFire = (stateQ == DRR_BUSY) && engRsp.done && !clearFsm;

    a_clear_forces_idle: assert property (@(posedge clk) disable iff (!rstn)
        clearFsm |=> (stateQ == DRR_IDLE))
        else $error("Channel clear did not return the machine to idle.");

    a_busy_waits_done: assert property (@(posedge clk) disable iff (!rstn)
        (stateQ == DRR_BUSY) && !engRsp.done && !clearFsm |=> (stateQ == DRR_BUSY))
        else $error("Busy channel left busy without done or clear.");

endmodule // drr_chan_fsm

// >>> rtl/drr_router.sv
// Routes one of sixteen peripheral DMA requests to DMA channel 1 and steers the completion
// handshake back to the chosen requester; holds the shared routing register.
// Assumes a plain register port with read data one cycle after the read strobe.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "drr_regs.svh"

module drr_router
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rstn,
    // Register port
    input  wire logic [`DRR_ADDR_W-1:0]       regAddr,
    input  wire logic [`DRR_DATA_W-1:0]       regWdata,
    input  wire logic                         regWr,
    input  wire logic                         regRd,
    output logic      [`DRR_DATA_W-1:0]       regRdata,
    // Peripheral requesters
    input  wire logic [`DRR_NUM_REQ-1:0]      perReq,
    output drr_pkg::drr_per_rsp_t             perRsp,
    // Channel-1 engine
    output logic                              engReq,
    input  wire drr_pkg::drr_eng_rsp_t        engRsp
);
    import drr_pkg::*;

    // One-hot decode of a selector; used for both acknowledge and done steering.
    function automatic logic [`DRR_NUM_REQ-1:0] selDecode(input drr_sel_t sel,
                                                          input logic     fire);
        logic [`DRR_NUM_REQ-1:0] vec;
        vec      = '0;
        vec[sel] = fire;
        return vec;
    endfunction

    // Builds the read image of one channel lane: clear bit and reserved bits read zero.
    function automatic logic [`DRR_CHAN_LANE_W-1:0] laneImage(input drr_sel_t sel);
        return {4'h0, sel};
    endfunction

    logic                    routeWr;
    logic                    statWr;
    logic                    clearCh1;
    drr_sel_t                selQ [`DRR_NUM_CHAN];
    drr_sel_t                ch1Sel;
    logic [`DRR_DATA_W-1:0]  routeImage;
    logic [`DRR_DATA_W-1:0]  statImage;
    logic [`DRR_DATA_W-1:0]  rdataD;
    logic [`DRR_DATA_W-1:0]  regRdataQ;
    logic                    ch1ReqIn;
    logic                    ackFire;
    logic                    doneFire;
    drr_state_t              ch1State;

    assign routeWr  = regWr && (regAddr == `DRR_ROUTE_OFS);
    assign statWr   = regWr && (regAddr == `DRR_STAT_OFS);
    // Only a one in the clear bit acts; a zero leaves the machine alone.
    assign clearCh1 = routeWr && regWdata[`DRR_CH1_CLR_BIT];

    // Selector storage for all four channels; lane c sits at bits (3-c)*8 upward.
    // Only channel 1 is wired to routing here; the others are held for their own routers.
    genvar c;
    generate
        for (c = 0; c < `DRR_NUM_CHAN; c++)
        begin : g_lane
            localparam int LO = (`DRR_NUM_CHAN - 1 - c) * `DRR_CHAN_LANE_W;
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    selQ[c] <= `DRR_SEL_RST;
                else if (routeWr)
                    selQ[c] <= regWdata[LO +: `DRR_SEL_W];
            end
            assign routeImage[LO +: `DRR_CHAN_LANE_W] = laneImage(selQ[c]);
        end
    endgenerate

    assign ch1Sel   = selQ[1];
    // Request input n reaches the channel when the selector holds n.
    assign ch1ReqIn = perReq[ch1Sel];

    drr_chan_fsm u_ch1
    (
        .clk      (clk),
        .rstn     (rstn),
        .clearFsm (clearCh1),
        .reqIn    (ch1ReqIn),
        .engRsp   (engRsp),
        .engReq   (engReq),
        .state    (ch1State),
        .ackFire  (ackFire),
        .doneFire (doneFire)
    );

    // Completion goes only to the requester the selector names at that moment; a
    // selector rewritten mid-transfer without a clear therefore misdirects it.
    assign perRsp.ack  = selDecode(ch1Sel, ackFire);
    assign perRsp.done = selDecode(ch1Sel, doneFire);

    always_comb
    begin
        statImage = '0;
        statImage[`DRR_STAT_STATE_LO +: 2] = ch1State;
        statImage[`DRR_STAT_REQ_BIT]       = engReq;
    end

    // Status is read-only, so a write to it is dropped like an unmapped one.
    always_comb
    begin
        rdataD = '0;
        if (regRd)
        begin
            unique case (regAddr)
                `DRR_ROUTE_OFS: rdataD = routeImage;
                `DRR_STAT_OFS:  rdataD = statImage;
                default:        rdataD = '0;
            endcase
        end
    end

    // Read data stand for the single cycle after the strobe and read zero otherwise.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            regRdataQ <= `DRR_ROUTE_RST;
        else
            regRdataQ <= rdataD;
    end

    assign regRdata = regRdataQ;

    a_clear_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
        regRd && (regAddr == `DRR_ROUTE_OFS) |=> (regRdata[`DRR_CH1_CLR_BIT] == 1'b0))
        else $error("Channel-1 clear bit read back as one.");

    a_reserved_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
        (regRdata[`DRR_CH1_RSV_HI:`DRR_CH1_RSV_LO] == 3'h0))
        else $error("Reserved bits 22 to 20 read nonzero.");

    a_sel_readback: assert property (@(posedge clk) disable iff (!rstn)
        routeWr ##1 (regRd && (regAddr == `DRR_ROUTE_OFS) && !regWr)
        |=> (regRdata[`DRR_CH1_SEL_HI:`DRR_CH1_SEL_LO] == $past(regWdata[19:16], 2)))
        else $error("Channel-1 selector did not read back as written.");

    a_other_lane_stored: assert property (@(posedge clk) disable iff (!rstn)
        routeWr |=> (selQ[0] == $past(regWdata[27:24])) && (selQ[3] == $past(regWdata[3:0])))
        else $error("Other channel selectors were not stored independently.");

    a_write_one_clears: assert property (@(posedge clk) disable iff (!rstn)
        (ch1State != DRR_IDLE) && routeWr && regWdata[`DRR_CH1_CLR_BIT]
        |=> (ch1State == DRR_IDLE) && !engReq)
        else $error("Writing one to the clear bit left the channel active.");

    a_write_zero_keeps: assert property (@(posedge clk) disable iff (!rstn)
        (ch1State == DRR_PEND) && routeWr && !regWdata[`DRR_CH1_CLR_BIT] && !engRsp.ack
        |=> (ch1State == DRR_PEND))
        else $error("Writing zero to the clear bit disturbed the channel.");

    a_route_request: assert property (@(posedge clk) disable iff (!rstn)
        (ch1State == DRR_IDLE) && perReq[ch1Sel] && !clearCh1
        |=> (ch1State == DRR_PEND) && (engReq == !clearCh1))
        else $error("Selected request input did not reach channel 1.");

    a_ack_to_selected: assert property (@(posedge clk) disable iff (!rstn)
        (perRsp.ack != '0) || (perRsp.done != '0)
        |-> ((perRsp.ack | perRsp.done) == (16'h0001 << ch1Sel)))
        else $error("Completion went to a requester other than the selected one.");

    a_clear_drops_hs: assert property (@(posedge clk) disable iff (!rstn)
        clearCh1 |-> (perRsp.ack == '0) && (perRsp.done == '0) && !engReq)
        else $error("Handshake leaked in the cycle of a channel clear.");

    a_rdata_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
        !$past(regRd) |-> (regRdata == '0))
        else $error("Read data stood outside the cycle after a read.");

endmodule // drr_router

// >>> test/drr_eng_model.sv
// Behavioural channel-1 engine: one ack pulse after a raised request, then one done pulse.
// Assumes the router holds its request until ack; ansDly sets the pace of each answer.
module drr_eng_model
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Router side
    input  wire logic             engReq,
    output drr_pkg::drr_eng_rsp_t engRsp,
    // Answer pace in cycles
    input  wire logic [3:0]       ansDly
);
    timeunit 1ns;
    timeprecision 1ps;
    import drr_pkg::*;

    logic       busy_q;
    logic [3:0] cnt_q;

    // A slow pace keeps the router waiting, so clears can land mid-transfer.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            engRsp <= '0;
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
        end
        else
        begin
            engRsp <= '0;
            if ((busy_q || engReq) && cnt_q < ansDly)
                cnt_q <= cnt_q + 4'h1;
            else if (busy_q || engReq)
            begin
                engRsp.ack  <= !busy_q;
                engRsp.done <= busy_q;
                busy_q      <= !busy_q;
                cnt_q       <= 4'h0;
            end
            // A request withdrawn by a clear restarts the pace count.
            else
                cnt_q <= 4'h0;
        end
    end
endmodule // drr_eng_model

// >>> test/drr_router_test.sv
// Self-checking bench of the channel-1 request router, random with corner cases.
// Assumes drr_eng_model as the engine; the bench plays software and the requesters.
`include "drr_regs.svh"

module drr_router_test;
    timeunit 1ns;
    timeprecision 1ps;
    import drr_pkg::*;

    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic [7:0]   regAddr = 8'h00;
    logic [31:0]  regWdata = 32'h0;
    logic         regWr = 1'b0;
    logic         regRd = 1'b0;
    logic [31:0]  regRdata;
    logic [15:0]  perReq = 16'h0;
    drr_per_rsp_t perRsp;
    logic         engReq;
    drr_eng_rsp_t engRsp;
    logic [3:0]   ansDly = 4'h0;
    logic [31:0]  w;
    int           fail_count = 0;
    int           compares = 0;
    int           cyc = 0;

    drr_router dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .perReq(perReq),
        .perRsp(perRsp), .engReq(engReq), .engRsp(engRsp));
    drr_eng_model eng_u (.clk(clk), .rstn(rstn), .engReq(engReq), .engRsp(engRsp),
        .ansDly(ansDly));

    initial forever #2.5 clk = ~clk;

    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles; this ceiling only cuts a hang.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The trailing idle cycle keeps a following strobe off the same time step.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    // Write and read back with no gap between the strobes, as the port allows.
    task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d,
                             input logic [31:0] exp);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
        @(posedge clk);
    endtask

    // One full transfer from requester n; other requesters raise noise first.
    task automatic xfer(input int n);
        logic [15:0] hot;
        int          acks;
        hot = 16'h0001 << n;
        acks = 0;
        perReq <= ~hot;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(32'(engReq), 32'h0);
        @(posedge clk);
        perReq <= 16'($urandom) | hot;
        repeat (40)
        begin
            @(negedge clk);
            if (perRsp.ack !== 16'h0)
            begin
                chk(32'(perRsp.ack), 32'(hot));
                acks++;
            end
            if (perRsp.done !== 16'h0)
                break;
        end
        chk(32'(perRsp.done), 32'(hot));
        chk(32'(acks), 32'h1);
        @(posedge clk);
        perReq <= 16'h0;
        @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(14551));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(`DRR_ROUTE_OFS, `DRR_ROUTE_RST);
        rd_chk(`DRR_STAT_OFS, 32'h0);
        repeat (8)
        begin
            w = $urandom;
            wr_rd_chk(`DRR_ROUTE_OFS, w, w & 32'h0f0f_0f0f);
        end
        wr_reg(8'h08, $urandom);
        wr_reg(`DRR_STAT_OFS, $urandom);
        rd_chk(8'h08, 32'h0);
        rd_chk(`DRR_STAT_OFS, 32'h0);
        rd_chk(`DRR_ROUTE_OFS, w & 32'h0f0f_0f0f);
        for (int n = 0; n < 16; n++)
        begin
            ansDly <= 4'(3 * (n % 3));
            wr_reg(`DRR_ROUTE_OFS, {8'h00, 8'h80 | 8'(n), 16'h0});
            xfer(n);
        end
        // Slow engine: a zero clear bit must leave the pending request alone.
        ansDly <= 4'd15;
        wr_reg(`DRR_ROUTE_OFS, 32'h0085_0000);
        perReq <= 16'h0020;
        repeat (3) @(posedge clk);
        wr_reg(`DRR_ROUTE_OFS, 32'h0005_0000);
        rd_chk(`DRR_STAT_OFS, 32'h0000_0005);
        // The request drops with the clear, so it is not taken again right after it.
        perReq <= 16'h0;
        wr_reg(`DRR_ROUTE_OFS, 32'h0085_0000);
        @(negedge clk);
        chk(32'(engReq), 32'h0);
        @(posedge clk);
        rd_chk(`DRR_STAT_OFS, 32'h0);
        // Clear while busy: the engine's late done must reach no requester.
        ansDly <= 4'd8;
        perReq <= 16'h0020;
        repeat (40)
        begin
            @(negedge clk);
            if (perRsp.ack !== 16'h0)
                break;
        end
        chk(32'(perRsp.ack), 32'h0000_0020);
        @(posedge clk);
        perReq <= 16'h0;
        wr_reg(`DRR_ROUTE_OFS, 32'h0085_0000);
        rd_chk(`DRR_STAT_OFS, 32'h0);
        repeat (20)
        begin
            @(negedge clk);
            chk(32'(perRsp.ack | perRsp.done), 32'h0);
        end
        @(posedge clk);
        ansDly <= 4'd2;
        xfer(5);
        // Reset in mid-run: selectors, state and read data return to reset values.
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(`DRR_ROUTE_OFS, `DRR_ROUTE_RST);
        rd_chk(`DRR_STAT_OFS, 32'h0);
        wrap_up();
    end
endmodule // drr_router_test
